// >>> verilog/cwt_pkg.sv
package cwt_pkg;

	// Prescaler and counter chained as one 18-bit value.
	localparam int CNT_W = 18;
	localparam int PRE_W = 12;
	localparam int SVC_LSB = 4;
	localparam int SHORT_MSB = 12;
	localparam logic [CNT_W-1:0] CNT_CLEAR = 18'h00000;

	// Reset pin drive length in crystal ticks.
	localparam int RST_TICKS = 32;
	localparam logic [4:0] RST_LAST = 5'h1f;
	localparam logic [4:0] RST_FIRST = 5'h00;

	// Power-on prescaler clear delay in crystal ticks.
	localparam logic [12:0] POR_LAST = 13'h0fff;
	localparam logic [12:0] POR_ONE = 13'h0001;

	// Register indices; the byte address is four times the index.
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 17;
	localparam logic [15:0] IDX_SERVICE = 16'hffff;
	localparam logic [15:0] IDX_CONFIG = 16'h0000;
	localparam logic [15:0] IDX_STATUS = 16'h0001;
	localparam logic [15:0] IDX_MASK = 16'h0002;
	localparam logic [15:0] IDX_COUNT = 16'h0003;

	// Field positions.
	localparam int CFG_DIS_BIT = 0;
	localparam int CFG_RATE_BIT = 1;
	localparam int CFG_STOP_BIT = 2;
	localparam int CFG_LOCK_BIT = 3;
	localparam int CFG_RUN_BIT = 8;
	localparam int ST_W = 2;
	localparam int ST_WDG_BIT = 0;
	localparam int ST_ILL_BIT = 1;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic watchdog_disable_bit;
		logic timeout_rate_select;
		logic stop_enable;
	} cwt_cfg_t;

	typedef struct packed {
		logic stop_exec;
		logic vector_fetch;
		logic internal_reset;
		logic stop_mode;
		logic monitor_mode;
		logic break_state;
		logic rst_vtst;
		logic irq_vtst;
		logic blank_vec_entry;
	} cwt_sys_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic ovf;
	} cwt_cnt_st_t;

	typedef enum logic {
		PS_IDLE = 1'b0,
		PS_DRIVE = 1'b1
	} cwt_pls_mode_t;

	typedef struct packed {
		cwt_pls_mode_t mode;
		logic [4:0] cnt;
		logic pin_n;
		logic pin_oe;
	} cwt_pls_st_t;

	typedef struct packed {
		cwt_cfg_t cfg;
		logic cfg_lock;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic blank_lock;
		logic [12:0] por_cnt;
		logic por_done;
		logic dp_wr;
		logic [15:0] dp_idx;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic irq;
		logic wdg_rst;
		logic ill_rst;
	} cwt_top_st_t;

	localparam cwt_top_st_t TOP_RESET = '{hreadyout: 1'b1, default: '0};

endpackage : cwt_pkg

// >>> verilog/cwt_counter.sv
`timescale 1ns/1ns
module cwt_counter (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick,
	input wire logic run,
	input wire logic clr_all,
	input wire logic clr_svc,
	input wire logic clr_pre,
	input wire logic rate_short,
	output logic ovf_q,
	output logic [cwt_pkg::CNT_W-1:0] count_q
);
	cwt_pkg::cwt_cnt_st_t st_q, st_d;
	logic term;

	// Short rate rolls over at the 13-bit boundary, long rate at the full 18 bits.
	assign term = rate_short ? (&st_q.cnt[cwt_pkg::SHORT_MSB:0]) : (&st_q.cnt);

	always_comb
	begin
		st_d = st_q;
		st_d.ovf = 1'b0;
		if (!run || clr_all)
		begin
			st_d.cnt = cwt_pkg::CNT_CLEAR;
		end
		else if (clr_svc || clr_pre)
		begin
			if (clr_pre)
				st_d.cnt[cwt_pkg::PRE_W-1:0] = '0;
			if (clr_svc)
				st_d.cnt[cwt_pkg::CNT_W-1:cwt_pkg::SVC_LSB] = '0;
		end
		else if (tick)
		begin
			st_d.ovf = term;
			st_d.cnt = st_q.cnt + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign ovf_q = st_q.ovf;
	assign count_q = st_q.cnt;

	a_long_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
		run && !clr_all && !clr_svc && !clr_pre && tick && !rate_short && (&st_q.cnt)
		|=> ovf_q && (st_q.cnt == cwt_pkg::CNT_CLEAR))
		else $error("long timeout overflow missed");

	a_short_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
		run && !clr_all && !clr_svc && !clr_pre && tick && rate_short
		|=> ovf_q == $past(&st_q.cnt[cwt_pkg::SHORT_MSB:0]))
		else $error("short timeout overflow wrong");

	a_service_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		clr_svc |=> (st_q.cnt[cwt_pkg::CNT_W-1:cwt_pkg::SVC_LSB] == '0) && !ovf_q)
		else $error("service did not clear counter");

	a_pre_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		clr_pre |=> st_q.cnt[cwt_pkg::PRE_W-1:0] == '0)
		else $error("prescaler not cleared");

	a_off_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		(!run || clr_all) |=> (st_q.cnt == cwt_pkg::CNT_CLEAR) && !ovf_q)
		else $error("counter not held clear");

endmodule : cwt_counter

// >>> verilog/cwt_pulse.sv
`timescale 1ns/1ns
module cwt_pulse (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic start,
	input wire logic tick,
	output logic pin_n_q,
	output logic pin_oe_q
);
	cwt_pkg::cwt_pls_st_t st_q, st_d;
	logic [5:0] h_ticks;

	always_comb
	begin
		st_d = st_q;
		if (start)
		begin
			st_d.mode = cwt_pkg::PS_DRIVE;
			st_d.cnt = cwt_pkg::RST_FIRST;
			st_d.pin_n = 1'b0;
			st_d.pin_oe = 1'b1;
		end
		else
		begin
			case (st_q.mode)
				cwt_pkg::PS_IDLE:
				begin
					st_d.pin_n = 1'b1;
					st_d.pin_oe = 1'b0;
				end
				cwt_pkg::PS_DRIVE:
				begin
					if (tick && st_q.cnt == cwt_pkg::RST_LAST)
					begin
						st_d.mode = cwt_pkg::PS_IDLE;
						st_d.pin_n = 1'b1;
						st_d.pin_oe = 1'b0;
					end
					else if (tick)
						st_d.cnt = st_q.cnt + 1'b1;
				end
				default:
				begin
					st_d.mode = cwt_pkg::PS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= '{mode: cwt_pkg::PS_IDLE, cnt: '0, pin_n: 1'b1, pin_oe: 1'b0};
		else
			st_q <= st_d;
	end

	assign pin_n_q = st_q.pin_n;
	assign pin_oe_q = st_q.pin_oe;

	// Counts crystal ticks seen while the pin is driven.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			h_ticks <= '0;
		else if (start)
			h_ticks <= '0;
		else if (st_q.mode == cwt_pkg::PS_DRIVE && tick)
			h_ticks <= h_ticks + 1'b1;
	end

	a_pin_low_len: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(pin_oe_q) |-> h_ticks == 6'(cwt_pkg::RST_TICKS))
		else $error("reset pin low length wrong");

endmodule : cwt_pulse

// >>> verilog/cwt_top.sv
`timescale 1ns/1ns
module cwt_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic crystal_clock_tick,
	input wire cwt_pkg::cwt_sys_t sys,
	input wire logic [7:0] reset_vector_lo,
	output logic rst_pin_out_n,
	output logic rst_pin_oe,
	output logic wdg_reset,
	output logic illegal_reset,
	output logic irq
);
	cwt_pkg::cwt_top_st_t st_q, st_d;

	logic ap_valid;
	logic ap_mapped;
	logic ap_read;
	logic ap_write;
	logic [15:0] ap_idx;
	logic tick_g;
	logic wdg_off;
	logic clr_pre;
	logic clr_all;
	logic svc;
	logic por_clr;
	logic ill_evt;
	logic cnt_ovf;
	logic [cwt_pkg::CNT_W-1:0] cnt_val;
	logic [cwt_pkg::ST_W-1:0] st_set;
	logic [cwt_pkg::ST_W-1:0] st_rdclr;
	logic [31:0] cfg_view;

	// Address phase decode; only whole-word transfers reach a register.
	assign ap_valid = hsel && hready && (htrans == cwt_pkg::HTRANS_NONSEQ ||
		htrans == cwt_pkg::HTRANS_SEQ);
	assign ap_idx = haddr[cwt_pkg::IDX_MSB:cwt_pkg::IDX_LSB];
	assign ap_mapped = (haddr[31:cwt_pkg::IDX_MSB+1] == '0) &&
		(haddr[cwt_pkg::IDX_LSB-1:0] == '0) && (hsize == cwt_pkg::HSIZE_WORD) &&
		(ap_idx == cwt_pkg::IDX_SERVICE || ap_idx == cwt_pkg::IDX_CONFIG ||
		ap_idx == cwt_pkg::IDX_STATUS || ap_idx == cwt_pkg::IDX_MASK ||
		ap_idx == cwt_pkg::IDX_COUNT);
	assign ap_read = ap_valid && ap_mapped && !hwrite;
	assign ap_write = ap_valid && ap_mapped && hwrite;

	// Stop mode removes crystal ticks; wait mode does not, so counting goes on.
	assign tick_g = crystal_clock_tick && !sys.stop_mode;

	// Test voltage and blank-vector lock override the configuration.
	assign wdg_off = st_q.cfg.watchdog_disable_bit || st_q.blank_lock ||
		(sys.monitor_mode && (sys.rst_vtst || sys.irq_vtst)) ||
		(sys.break_state && sys.rst_vtst);

	// Service happens in the write data phase, whatever the data.
	assign svc = st_q.dp_wr && (st_q.dp_idx == cwt_pkg::IDX_SERVICE);

	assign por_clr = !st_q.por_done && crystal_clock_tick &&
		(st_q.por_cnt == cwt_pkg::POR_LAST);

	assign ill_evt = sys.stop_exec && !st_q.cfg.stop_enable;

	assign clr_pre = por_clr || sys.vector_fetch ||
		(sys.stop_exec && st_q.cfg.stop_enable);

	// Our own resets count as internal resets and restart the count.
	assign clr_all = sys.internal_reset || cnt_ovf || st_q.ill_rst;

	assign st_set = {ill_evt, cnt_ovf};
	assign st_rdclr = {cwt_pkg::ST_W{ap_read && ap_idx == cwt_pkg::IDX_STATUS}};

	always_comb
	begin
		cfg_view = '0;
		cfg_view[cwt_pkg::CFG_DIS_BIT] = st_q.cfg.watchdog_disable_bit;
		cfg_view[cwt_pkg::CFG_RATE_BIT] = st_q.cfg.timeout_rate_select;
		cfg_view[cwt_pkg::CFG_STOP_BIT] = st_q.cfg.stop_enable;
		cfg_view[cwt_pkg::CFG_LOCK_BIT] = st_q.cfg_lock;
		cfg_view[cwt_pkg::CFG_RUN_BIT] = !wdg_off;
	end

	cwt_counter i_cwt_counter (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick_g),
		.run(!wdg_off),
		.clr_all(clr_all),
		.clr_svc(svc),
		.clr_pre(clr_pre),
		.rate_short(st_q.cfg.timeout_rate_select),
		.ovf_q(cnt_ovf),
		.count_q(cnt_val)
	);

	cwt_pulse i_cwt_pulse (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(cnt_ovf),
		.tick(crystal_clock_tick),
		.pin_n_q(rst_pin_out_n),
		.pin_oe_q(rst_pin_oe)
	);

	always_comb
	begin
		st_d = st_q;
		st_d.hreadyout = 1'b1;
		st_d.hresp = cwt_pkg::HRESP_OKAY;
		st_d.dp_wr = ap_write;
		st_d.dp_idx = ap_write ? ap_idx : st_q.dp_idx;
		st_d.hrdata = '0;
		st_d.wdg_rst = cnt_ovf;
		st_d.ill_rst = ill_evt;

		// Read data is fetched in the address phase and stands in the data phase.
		if (ap_read)
		begin
			case (ap_idx)
				cwt_pkg::IDX_SERVICE: st_d.hrdata = {24'h000000, reset_vector_lo};
				cwt_pkg::IDX_CONFIG: st_d.hrdata = cfg_view;
				cwt_pkg::IDX_STATUS: st_d.hrdata = {{(32-cwt_pkg::ST_W){1'b0}}, st_q.status};
				cwt_pkg::IDX_MASK: st_d.hrdata = {{(32-cwt_pkg::ST_W){1'b0}}, st_q.mask};
				cwt_pkg::IDX_COUNT: st_d.hrdata = {{(32-cwt_pkg::CNT_W){1'b0}}, cnt_val};
				default: st_d.hrdata = '0;
			endcase
		end

		// Write data phase; the configuration takes one write per reset.
		if (st_q.dp_wr)
		begin
			case (st_q.dp_idx)
				cwt_pkg::IDX_CONFIG:
				begin
					if (!st_q.cfg_lock)
					begin
						st_d.cfg.watchdog_disable_bit = hwdata[cwt_pkg::CFG_DIS_BIT];
						st_d.cfg.timeout_rate_select = hwdata[cwt_pkg::CFG_RATE_BIT];
						st_d.cfg.stop_enable = hwdata[cwt_pkg::CFG_STOP_BIT];
						st_d.cfg_lock = 1'b1;
					end
				end
				cwt_pkg::IDX_MASK: st_d.mask = hwdata[cwt_pkg::ST_W-1:0];
				default:
				begin
					st_d.cfg_lock = st_q.cfg_lock;
				end
			endcase
		end

		// A new event wins over the read that clears it.
		st_d.status = (st_q.status & ~st_rdclr) | st_set;

		st_d.blank_lock = st_q.blank_lock || sys.blank_vec_entry;

		if (!st_q.por_done && crystal_clock_tick)
		begin
			st_d.por_cnt = st_q.por_cnt + cwt_pkg::POR_ONE;
			st_d.por_done = por_clr;
		end

		// A level interrupt for the system, never a processor request of its own.
		st_d.irq = |(st_d.status & st_d.mask);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_q <= cwt_pkg::TOP_RESET;
		else
			st_q <= st_d;
	end

	assign hreadyout = st_q.hreadyout;
	assign hresp = st_q.hresp;
	assign hrdata = st_q.hrdata;
	assign wdg_reset = st_q.wdg_rst;
	assign illegal_reset = st_q.ill_rst;
	assign irq = st_q.irq;

	a_vector_read: assert property (@(posedge hclk) disable iff (!hresetn)
		ap_read && ap_idx == cwt_pkg::IDX_SERVICE
		|=> hrdata == {24'h000000, $past(reset_vector_lo)})
		else $error("service read not vector byte");

	a_wdg_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		cnt_ovf |=> st_q.status[cwt_pkg::ST_WDG_BIT] && wdg_reset && rst_pin_oe && !rst_pin_out_n)
		else $error("watchdog reset effects missing");

	a_illegal_stop: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.stop_exec |=> illegal_reset == !$past(st_q.cfg.stop_enable))
		else $error("stop opcode handling wrong");

	a_disable_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		wdg_off |=> !cnt_ovf && cnt_val == cwt_pkg::CNT_CLEAR)
		else $error("disabled watchdog still counts");

	a_vtst_disable: assert property (@(posedge hclk) disable iff (!hresetn)
		(sys.break_state && sys.rst_vtst) || (sys.monitor_mode && sys.irq_vtst) |-> wdg_off)
		else $error("test voltage did not disable");

	a_blank_lock: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.blank_vec_entry |=> wdg_off [*8])
		else $error("blank vector lock released");

	a_stop_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.stop_mode && !clr_all && !clr_pre && !svc && !wdg_off
		|=> cnt_val == $past(cnt_val))
		else $error("count moved in stop mode");

	a_rdata_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		!ap_read |=> hrdata == '0)
		else $error("read data left standing");

	a_status_rdclr: assert property (@(posedge hclk) disable iff (!hresetn)
		ap_read && ap_idx == cwt_pkg::IDX_STATUS && st_set == '0
		|=> st_q.status == '0)
		else $error("status read did not clear");

	a_ill_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		ill_evt |=> st_q.status[cwt_pkg::ST_ILL_BIT] && illegal_reset)
		else $error("illegal stop effects missing");

	a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == ((st_q.status & st_q.mask) != '0))
		else $error("interrupt level wrong");

	a_cfg_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.cfg_lock |=> st_q.cfg == $past(st_q.cfg))
		else $error("locked configuration changed");

	a_cfg_write: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.dp_wr && st_q.dp_idx == cwt_pkg::IDX_CONFIG && !st_q.cfg_lock
		|=> st_q.cfg_lock &&
		st_q.cfg.timeout_rate_select == $past(hwdata[cwt_pkg::CFG_RATE_BIT]))
		else $error("configuration write lost");

	a_mask_write: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.dp_wr && st_q.dp_idx == cwt_pkg::IDX_MASK
		|=> st_q.mask == $past(hwdata[cwt_pkg::ST_W-1:0]))
		else $error("mask write lost");

	a_por_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		por_clr |=> st_q.por_done && cnt_val[cwt_pkg::PRE_W-1:0] == '0)
		else $error("power-on prescaler clear missed");

	a_vf_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.vector_fetch |=> cnt_val[cwt_pkg::PRE_W-1:0] == '0)
		else $error("vector fetch did not clear prescaler");

	a_stop_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.stop_exec && st_q.cfg.stop_enable
		|=> cnt_val[cwt_pkg::PRE_W-1:0] == '0)
		else $error("stop did not clear prescaler");

	a_int_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		sys.internal_reset |=> cnt_val == cwt_pkg::CNT_CLEAR && !cnt_ovf)
		else $error("internal reset did not clear");

	a_wait_count: assert property (@(posedge hclk) disable iff (!hresetn)
		tick_g && !wdg_off && !clr_all && !clr_pre && !svc
		|=> cnt_val == $past(cnt_val) + 1'b1)
		else $error("count missed a tick");

	a_pin_pair: assert property (@(posedge hclk) disable iff (!hresetn)
		rst_pin_out_n == !rst_pin_oe)
		else $error("reset pin drive inconsistent");

	a_off_no_reset: assert property (@(posedge hclk) disable iff (!hresetn)
		wdg_off |-> ##2 !wdg_reset)
		else $error("disabled watchdog raised reset");

	a_blank_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q.blank_lock |=> st_q.blank_lock && wdg_off)
		else $error("blank vector lock dropped");

	a_run_bit: assert property (@(posedge hclk) disable iff (!hresetn)
		ap_read && ap_idx == cwt_pkg::IDX_CONFIG
		|=> hrdata[cwt_pkg::CFG_RUN_BIT] == !$past(wdg_off))
		else $error("running bit wrong");

	a_count_read: assert property (@(posedge hclk) disable iff (!hresetn)
		ap_read && ap_idx == cwt_pkg::IDX_COUNT
		|=> hrdata == {{(32-cwt_pkg::CNT_W){1'b0}}, $past(cnt_val)})
		else $error("count read wrong");

endmodule : cwt_top

// >>> bench/cwt_top_tb.sv
`timescale 1ns/1ns
module cwt_top_tb;
	localparam logic [31:0] A_CFG = 32'h0;
	localparam logic [31:0] A_ST = 32'h4;
	localparam logic [31:0] A_MSK = 32'h8;
	localparam logic [31:0] A_CNT = 32'hc;
	localparam logic [31:0] A_SVC = {14'h0, cwt_pkg::IDX_SERVICE, 2'h0};
	localparam logic [8:0] S_STOP = 9'h100;
	localparam logic [8:0] S_VF = 9'h080;
	localparam logic [8:0] S_IR = 9'h040;
	localparam logic [8:0] S_SM = 9'h020;
	localparam logic [8:0] S_MON = 9'h010;
	localparam logic [8:0] S_BRK = 9'h008;
	localparam logic [8:0] S_RV = 9'h004;
	localparam logic [8:0] S_IV = 9'h002;
	localparam logic [8:0] S_BL = 9'h001;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, rst_pin_out_n, rst_pin_oe, wdg_reset, illegal_reset, irq;
	logic [31:0] hrdata;
	logic crystal_clock_tick = 1'b0;
	logic tick_en = 1'b0;
	logic [8:0] sys_v = 9'h0;
	logic [7:0] rvl = 8'h0;
	logic ph = 1'b0;
	logic [31:0] seed = 32'd91;
	logic [31:0] eq[$];
	string nq[$];
	int miscompares = 0;
	int total_checks = 0;
	int n_wdg = 0;
	int n_ill = 0;
	int n;

	cwt_top i_cwt_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.crystal_clock_tick(crystal_clock_tick), .sys(cwt_pkg::cwt_sys_t'(sys_v)),
		.reset_vector_lo(rvl), .rst_pin_out_n(rst_pin_out_n), .rst_pin_oe(rst_pin_oe),
		.wdg_reset(wdg_reset), .illegal_reset(illegal_reset), .irq(irq));

	always #50 hclk = ~hclk;

	always @(posedge hclk)
	begin
		crystal_clock_tick <= tick_en;
		ph <= hsel && hreadyout && htrans[1] && !hwrite;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// Read data is compared in the data phase against the oldest note.
	always @(negedge hclk)
	begin
		if (wdg_reset === 1'b1)
			n_wdg++;
		if (illegal_reset === 1'b1)
			n_ill++;
		if (ph === 1'b1)
			check("hresp", hresp, 32'h0);
		if (ph === 1'b1 && eq.size() > 0)
			check(nq.pop_front(), hrdata, eq.pop_front());
	end

	task automatic wait_ready();
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && k < 16)
		begin
			k++;
			@(posedge hclk);
		end
		if (k >= 16)
		begin
			miscompares++;
			test_done();
		end
	endtask : wait_ready

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= cwt_pkg::HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= wr;
		hsize <= cwt_pkg::HSIZE_WORD;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
	endtask : ahb

	task automatic rd(input string w, input logic [31:0] a, input logic [31:0] e);
		eq.push_back(e);
		nq.push_back(w);
		ahb(1'b0, a, 32'h0);
	endtask : rd

	task automatic ticks(input int k);
		tick_en <= 1'b1;
		repeat (k) @(posedge hclk);
		tick_en <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : ticks

	task automatic spulse(input logic [8:0] m);
		sys_v <= sys_v | m;
		@(posedge hclk);
		sys_v <= sys_v & ~m;
		repeat (3) @(posedge hclk);
	endtask : spulse

	initial
	begin
		repeat (100000) @(posedge hclk);
		miscompares++;
		test_done();
	end

	initial
	begin
		rvl = 8'h5a;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		check("pin_oe", rst_pin_oe, 32'h0);
		check("irq", irq, 32'h0);
		@(posedge hclk);
		ahb(1'b1, A_SVC, xs());
		repeat (3)
		begin
			rvl <= 8'(xs());
			@(posedge hclk);
			rd("service read", A_SVC, {24'h0, rvl});
		end
		ahb(1'b1, A_CFG, 32'h2);
		rd("config", A_CFG, 32'h10a);
		ahb(1'b1, A_MSK, 32'h3);
		sys_v <= S_MON | S_IV;
		ticks(4200);
		rd("count monitor", A_CNT, 32'h0);
		sys_v <= S_BRK | S_RV;
		ticks(300);
		rd("count break", A_CNT, 32'h0);
		sys_v <= 9'h0;
		$display("test disable states done");
		ticks(100);
		spulse(S_IR);
		rd("count internal reset", A_CNT, 32'h0);
		ticks(5000);
		rd("count ticks", A_CNT, 32'h1388);
		spulse(S_VF);
		rd("count vector fetch", A_CNT, 32'h1000);
		ticks(32'h388);
		ahb(1'b1, A_SVC, xs());
		rd("count service", A_CNT, 32'h8);
		sys_v <= S_SM;
		ticks(100);
		sys_v <= 9'h0;
		rd("count stop mode", A_CNT, 32'h8);
		$display("test counter clears done");
		spulse(S_IR);
		tick_en <= 1'b1;
		n = 0;
		while (wdg_reset !== 1'b1 && n < 9000)
		begin
			@(negedge hclk);
			n++;
		end
		check("timeout in range", n >= 8176 && n <= 8200, 32'h1);
		check("pin level", rst_pin_out_n, 32'h0);
		n = 0;
		while (rst_pin_oe === 1'b1 && n < 100)
		begin
			n++;
			@(negedge hclk);
		end
		check("pin drive length", n, 32'd32);
		check("irq raised", irq, 32'h1);
		@(posedge hclk);
		tick_en <= 1'b0;
		rd("status", A_ST, 32'h1);
		rd("status cleared", A_ST, 32'h0);
		check("irq cleared", irq, 32'h0);
		check("reset count", n_wdg, 32'h1);
		$display("test timeout done");
		spulse(S_STOP);
		check("illegal stop", n_ill, 32'h1);
		rd("status illegal", A_ST, 32'h2);
		spulse(S_BL);
		ticks(300);
		rd("count blank lock", A_CNT, 32'h0);
		spulse(S_IR);
		ticks(100);
		rd("count blank lock held", A_CNT, 32'h0);
		$display("test illegal stop and blank lock done");
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b1, A_SVC, xs());
		ahb(1'b1, A_CFG, 32'h5);
		rd("config disabled", A_CFG, 32'hd);
		ahb(1'b1, A_CFG, 32'h2);
		rd("config write once", A_CFG, 32'hd);
		ticks(9000);
		rd("count disabled", A_CNT, 32'h0);
		check("no reset disabled", n_wdg, 32'h1);
		spulse(S_STOP);
		check("stop enabled", n_ill, 32'h1);
		$display("test disabled done");
		test_done();
	end
endmodule : cwt_top_tb
